// File: rtl/olr_top.v
/*
 * Overtemperature fault limit, warning limit and fault response
 * commands, with limit checking, status flags, alert and retry control.
 * Assumes a command front end that presents decoded command codes with
 * one-cycle write and read strobes, all synchronous to SYS_CLK.
 */
`include "olr_defs.vh"

module olr_top (
    input wire SYS_CLK,
    input wire RSTN,
    input wire CE,
    input wire CMD_WR,
    input wire CMD_RD,
    input wire [7:0] CMD_CODE,
    input wire [15:0] CMD_WDATA,
    output reg [15:0] CMD_RDATA,
    output reg CMD_RVLD,
    input wire TEMP_VLD,
    input wire [11:0] TEMP_DEG,
    input wire BANDGAP_OT,
    input wire LIMIT_CHECK_OVERRIDE,
    input wire CLEAR_FAULTS,
    input wire [4:0] ALERT_MASK,
    input wire STORE_ALL,
    input wire RESTORE_ALL,
    input wire [7:0] NV_FLIM_IN,
    input wire NV_SEL_IN,
    input wire NV_RS_IN,
    input wire RISE_TICK,
    input wire OP_OFF,
    output reg NV_WR,
    output reg [7:0] NV_FLIM,
    output reg NV_SEL,
    output reg NV_RS,
    output reg [4:0] STATUS,
    output reg SMBALERT_N,
    output reg FAULT_FLAG,
    output reg WARN_FLAG,
    output wire OUT_SHUTDOWN,
    output wire RESTART_REQ
);
    // Default warning limit from a fault limit
    function [7:0] warn_dflt;
        input [7:0] flim;
        begin
            if (flim < (`OLR_WARN_FLOOR + `OLR_WARN_OFFS)) begin
                warn_dflt = `OLR_WARN_FLOOR;
            end else begin
                warn_dflt = flim - `OLR_WARN_OFFS;
            end
        end
    endfunction

    // Retry field valid only when all bits match
    function rs_legal;
        input [2:0] rs;
        begin
            rs_legal = (rs == 3'h0) || (rs == 3'h7);
        end
    endfunction

    reg [7:0] flim_q;
    reg [7:0] wlim_q;
    reg shutdown_select_q;
    reg retry_setting_q;
    reg bg_q;

    wire [7:0] wr_mant;
    wire [2:0] wr_rs;
    wire wr_flim;
    wire wr_wlim;
    wire wr_resp;
    wire flim_range_ok;
    wire wlim_range_ok;
    wire flim_order_ok;
    wire wlim_order_ok;
    wire flim_ok;
    wire wlim_ok;
    wire resp_ok;
    wire bad_wr;
    wire bg_rise;
    wire [15:0] lims;
    wire [1:0] flags;
    wire [1:0] sets;
    wire retry_trig;
    wire retry_cool;
    wire [7:0] resp_byte;
    reg [4:0] stat_set;
    reg [4:0] stat_d;
    reg [15:0] rdata_d;

    // Write decode; upper byte of limit words is ignored
    assign wr_mant = CMD_WDATA[7:0]; // see (RQ4)
    assign wr_rs = CMD_WDATA[`OLR_RESP_RS_HI:`OLR_RESP_RS_LO];
    assign wr_flim = CMD_WR && (CMD_CODE == `OLR_CMD_FLIM);
    assign wr_wlim = CMD_WR && (CMD_CODE == `OLR_CMD_WLIM);
    assign wr_resp = CMD_WR && (CMD_CODE == `OLR_CMD_RESP);

    // Range checks on limit mantissas
    assign flim_range_ok = (wr_mant >= `OLR_FLIM_MIN) &&
                           (wr_mant <= `OLR_FLIM_MAX); // see (RQ5)
    assign wlim_range_ok = (wr_mant >= `OLR_WLIM_MIN) &&
                           (wr_mant <= `OLR_WLIM_MAX);

    // Fault above warning, unless override is set
    assign flim_order_ok = LIMIT_CHECK_OVERRIDE ||
                           (wr_mant > wlim_q); // see (RQ2) see (RQ20)
    assign wlim_order_ok = LIMIT_CHECK_OVERRIDE ||
                           (wr_mant < flim_q); // see (RQ19) see (RQ20)

    // Acceptance of each command write
    assign flim_ok = flim_range_ok && flim_order_ok;
    assign wlim_ok = wlim_range_ok && wlim_order_ok;
    assign resp_ok = rs_legal(wr_rs); // see (RQ13)
    assign bad_wr = (wr_flim && !flim_ok) || (wr_wlim && !wlim_ok) ||
                    (wr_resp && !resp_ok);

    // Limit registers and response settings
    always @(posedge SYS_CLK) begin
        if (!RSTN) begin
            flim_q <= `OLR_FLIM_RST; // see (RQ5)
            wlim_q <= warn_dflt(`OLR_FLIM_RST); // see (RQ21)
            shutdown_select_q <= `OLR_SEL_RST; // see (RQ8)
            retry_setting_q <= `OLR_RS_RST;
        end else if (CE) begin
            if (RESTORE_ALL) begin
                flim_q <= NV_FLIM_IN;
                wlim_q <= warn_dflt(NV_FLIM_IN); // see (RQ21)
                shutdown_select_q <= NV_SEL_IN;
                retry_setting_q <= NV_RS_IN; // see (RQ14)
            end else begin
                if (wr_flim && flim_ok) begin
                    flim_q <= wr_mant;
                end
                if (wr_wlim && wlim_ok) begin
                    wlim_q <= wr_mant; // see (RQ19)
                end
                if (wr_resp && resp_ok) begin // see (RQ13)
                    shutdown_select_q <= CMD_WDATA[`OLR_RESP_SEL];
                    retry_setting_q <= CMD_WDATA[`OLR_RESP_RS_HI];
                end
            end
        end
    end

    // Nonvolatile image, captured on store-all
    always @(posedge SYS_CLK) begin
        if (!RSTN) begin
            NV_WR <= 1'b0;
            NV_FLIM <= `OLR_FLIM_RST;
            NV_SEL <= `OLR_SEL_RST;
            NV_RS <= `OLR_RS_RST;
        end else if (CE) begin
            NV_WR <= STORE_ALL;
            if (STORE_ALL) begin
                NV_FLIM <= flim_q; // see (RQ3)
                NV_SEL <= shutdown_select_q;
                NV_RS <= retry_setting_q; // see (RQ14)
            end
        end
    end

    // Fault and warning comparators, fault in lane 0
    assign lims = {wlim_q, flim_q};
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_cmp
            olr_hyst_cmp u_cmp (
                .clk(SYS_CLK),
                .rst_n(RSTN),
                .ce(CE),
                .smp_vld(TEMP_VLD),
                .temp(TEMP_DEG),
                .limit(lims[8*i+7:8*i]),
                .flag_q(flags[i]),
                .set_q(sets[i])
            );
        end
    endgenerate

    // Bandgap detector edge
    always @(posedge SYS_CLK) begin
        if (!RSTN) begin
            bg_q <= 1'b0;
        end else if (CE) begin
            bg_q <= BANDGAP_OT;
        end
    end
    assign bg_rise = BANDGAP_OT && !bg_q;

    // Status set terms
    always @* begin
        stat_set = 5'h00;
        stat_set[`OLR_ST_CML] = bad_wr; // see (RQ2) see (RQ13) see (RQ19)
        stat_set[`OLR_ST_IVD] = bad_wr;
        stat_set[`OLR_ST_OTF] = sets[0] || bg_rise; // see (RQ6) see (RQ8)
        stat_set[`OLR_ST_OTW] = sets[1]; // see (RQ17)
        stat_set[`OLR_ST_TEMP] = sets[0] || sets[1] || bg_rise;
    end

    // Sticky status, set wins over clear
    always @* begin
        stat_d = (STATUS & {`OLR_ST_W{!CLEAR_FAULTS}}) | stat_set;
    end

    // Status, flags and alert outputs
    always @(posedge SYS_CLK) begin
        if (!RSTN) begin
            STATUS <= 5'h00;
            SMBALERT_N <= 1'b1;
            FAULT_FLAG <= 1'b0;
            WARN_FLAG <= 1'b0;
        end else if (CE) begin
            STATUS <= stat_d;
            SMBALERT_N <= ~|(stat_d & ~ALERT_MASK); // see (RQ6) see (RQ17)
            FAULT_FLAG <= flags[0];
            WARN_FLAG <= flags[1];
        end
    end

    // Shutdown on selected fault or on any bandgap fault
    assign retry_trig = (sets[0] && shutdown_select_q) || bg_rise; // see (RQ9)
    assign retry_cool = !BANDGAP_OT &&
                        (!flags[0] || !shutdown_select_q); // see (RQ10)

    olr_retry_seq u_retry (
        .clk(SYS_CLK),
        .rst_n(RSTN),
        .ce(CE),
        .trig(retry_trig),
        .cool(retry_cool),
        .retry_on(retry_setting_q), // see (RQ11) see (RQ12)
        .rise_tick(RISE_TICK),
        .op_off(OP_OFF),
        .clr(CLEAR_FAULTS),
        .shutdown_q(OUT_SHUTDOWN),
        .restart_q(RESTART_REQ)
    );

    // Response byte, delay bits mirror bit 5
    assign resp_byte = {shutdown_select_q, 1'b0, {3{retry_setting_q}},
                        {3{retry_setting_q}}}; // see (RQ15)

    // Read data select
    always @* begin
        case (CMD_CODE)
            `OLR_CMD_FLIM: rdata_d = {`OLR_EXP_BYTE, flim_q}; // see (RQ4)
            `OLR_CMD_RESP: rdata_d = {8'h00, resp_byte};
            `OLR_CMD_WLIM: rdata_d = {`OLR_EXP_BYTE, wlim_q};
            default: rdata_d = 16'h0000;
        endcase
    end

    // Read answer one cycle after the strobe
    always @(posedge SYS_CLK) begin
        if (!RSTN) begin
            CMD_RDATA <= 16'h0000;
            CMD_RVLD <= 1'b0;
        end else if (CE) begin
            CMD_RVLD <= CMD_RD;
            if (CMD_RD) begin
                CMD_RDATA <= rdata_d;
            end
        end
    end
endmodule // olr_top

// File: rtl/olr_defs.vh
/*
 * Constants of the overtemperature limit and response block: command
 * codes, field positions, reset values, limit ranges and timing counts.
 * Assumes inclusion by bare name from every rtl file of the block.
 */
// Summary of operation
// (RQ1) Fault when temperature exceeds fault limit
// (RQ2) Fault limit not above warning: flag error
// (RQ3) Store-all saves fault limit to NV
// (RQ4) Fault exponent zero, upper byte read-only
// (RQ5) Fault limit resets 145, accepts 120..165
// (RQ6) Fault sets summary, fault bit, alert
// (RQ7) Fault flag releases 20 degrees below limit
// (RQ8) Select 0: keep running, flag, alert
// (RQ9) Select 1: shut down, then retry setting
// (RQ10) Bandgap faults always shut down, restart cool
// (RQ11) Retry 000: stay off until cleared
// (RQ12) Retry 111: restart endlessly until off
// (RQ13) Retry not 000/111: reject, flag error
// (RQ14) Only bit 5 stored for retry field
// (RQ15) Delay bits mirror bit 5; seven rises
// (RQ16) Warning when temperature exceeds warning limit
// (RQ17) Warning sets summary, warning bit, alert
// (RQ18) Warning flag releases 20 degrees below limit
// (RQ19) Warning not below fault: keep, flag error
// (RQ20) Limit override input skips consistency check
// (RQ21) Default warning is fault minus 25, min 100
// (RQ22) Comparisons re-evaluated on every sample
`ifndef OLR_DEFS_VH
`define OLR_DEFS_VH

// Command codes
`define OLR_CMD_FLIM 8'h4F
`define OLR_CMD_RESP 8'h50
`define OLR_CMD_WLIM 8'h51

// Response register fields
`define OLR_RESP_SEL 7
`define OLR_RESP_ZERO 6
`define OLR_RESP_RS_HI 5
`define OLR_RESP_RS_LO 3
`define OLR_RESP_TD_HI 2
`define OLR_RESP_TD_LO 0

// Reset values
`define OLR_FLIM_RST 8'h91
`define OLR_SEL_RST 1'b0
`define OLR_RS_RST 1'b1
`define OLR_EXP_BYTE 8'h00

// Limit ranges in degrees
`define OLR_FLIM_MIN 8'h78
`define OLR_FLIM_MAX 8'hA5
`define OLR_WLIM_MIN 8'h64
`define OLR_WLIM_MAX 8'h8C

// Warning default derivation
`define OLR_WARN_OFFS 8'h19
`define OLR_WARN_FLOOR 8'h64

// Hysteresis in degrees, at compare width
`define OLR_HYST 13'h0014

// Retry delay in rise times
`define OLR_RETRY_RISES 3'h7

// Status vector positions
`define OLR_ST_CML 0
`define OLR_ST_IVD 1
`define OLR_ST_TEMP 2
`define OLR_ST_OTF 3
`define OLR_ST_OTW 4
`define OLR_ST_W 5

`endif

// File: rtl/olr_hyst_cmp.v
/*
 * Limit comparator with latched flag and release hysteresis.
 * Assumes temperature samples arrive with a one-cycle valid strobe.
 */
`include "olr_defs.vh"

module olr_hyst_cmp (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire smp_vld,
    input wire [11:0] temp,
    input wire [7:0] limit,
    output reg flag_q,
    output reg set_q
);
    wire above;
    wire released;

    // Trip above limit, release at limit minus hysteresis
    assign above = {1'b0, temp} > {5'h00, limit};
    assign released = ({1'b0, temp} + `OLR_HYST) <= {5'h00, limit};

    // Flag latch, evaluated per sample
    always @(posedge clk) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
            set_q <= 1'b0;
        end else if (ce) begin
            set_q <= 1'b0;
            if (smp_vld) begin // see (RQ22)
                if (!flag_q && above) begin // see (RQ1) see (RQ16)
                    flag_q <= 1'b1;
                    set_q <= 1'b1;
                end else if (flag_q && released) begin // see (RQ7)
                    flag_q <= 1'b0; // see (RQ18)
                end
            end
        end
    end
endmodule // olr_hyst_cmp

// File: rtl/olr_retry_seq.v
/*
 * Shutdown and restart sequencer for overtemperature faults.
 * Assumes one rise_tick pulse per elapsed soft-start rise time.
 */
`include "olr_defs.vh"

module olr_retry_seq (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire trig,
    input wire cool,
    input wire retry_on,
    input wire rise_tick,
    input wire op_off,
    input wire clr,
    output reg shutdown_q,
    output reg restart_q
);
    localparam ST_IDLE = 2'b00;
    localparam ST_COOL = 2'b01;
    localparam ST_DELAY = 2'b10;
    localparam ST_HOLD = 2'b11;

    reg [1:0] st_q;
    reg [2:0] cnt_q;

    // Sequencer state machine
    always @(posedge clk) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            cnt_q <= 3'h0;
            shutdown_q <= 1'b0;
            restart_q <= 1'b0;
        end else if (ce) begin
            restart_q <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (trig) begin // see (RQ9)
                        st_q <= ST_COOL;
                        shutdown_q <= 1'b1;
                    end
                end
                ST_COOL: begin
                    cnt_q <= 3'h0;
                    if (op_off) begin
                        st_q <= ST_IDLE;
                        shutdown_q <= 1'b0;
                    end else if (cool) begin // see (RQ10)
                        st_q <= retry_on ? ST_DELAY : ST_HOLD; // see (RQ11)
                    end
                end
                ST_DELAY: begin
                    if (op_off) begin // see (RQ12)
                        st_q <= ST_IDLE;
                        shutdown_q <= 1'b0;
                    end else if (trig) begin
                        st_q <= ST_COOL;
                    end else if (rise_tick) begin
                        if (cnt_q == `OLR_RETRY_RISES - 3'h1) begin // see (RQ15)
                            st_q <= ST_IDLE;
                            shutdown_q <= 1'b0;
                            restart_q <= 1'b1; // see (RQ12)
                        end else begin
                            cnt_q <= cnt_q + 3'h1;
                        end
                    end
                end
                ST_HOLD: begin
                    if (clr) begin // see (RQ11)
                        st_q <= ST_IDLE;
                        shutdown_q <= 1'b0;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                    shutdown_q <= 1'b0;
                end
            endcase
        end
    end
endmodule // olr_retry_seq

// File: bench/olr_top_monitor.sv
/* Port checker for olr_top.
   Assumes binding into olr_top and that CE low freezes all state. */
`include "olr_defs.vh"
module olr_top_monitor (
    input wire SYS_CLK,
    input wire RSTN,
    input wire CE,
    input wire CMD_WR,
    input wire CMD_RD,
    input wire [7:0] CMD_CODE,
    input wire [15:0] CMD_WDATA,
    input wire [15:0] CMD_RDATA,
    input wire CMD_RVLD,
    input wire TEMP_VLD,
    input wire BANDGAP_OT,
    input wire CLEAR_FAULTS,
    input wire [4:0] ALERT_MASK,
    input wire STORE_ALL,
    input wire RISE_TICK,
    input wire NV_WR,
    input wire [4:0] STATUS,
    input wire SMBALERT_N,
    input wire FAULT_FLAG,
    input wire WARN_FLAG,
    input wire OUT_SHUTDOWN,
    input wire RESTART_REQ
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN || !CE);
    // Restart steps: tick seen while shut down, then output resumes
    sequence s_tick_in_sd;
        $past(RISE_TICK) && $past(OUT_SHUTDOWN);
    endsequence
    sequence s_resumed;
        !OUT_SHUTDOWN;
    endsequence
    property p_restart;
        RESTART_REQ |-> s_tick_in_sd ##0 s_resumed;
    endproperty
    a_restart: assert property (p_restart)
        else $error("restart without tick");
    property p_rvld;
        CMD_RD |=> CMD_RVLD && (CMD_RDATA[15:8] == 8'h00);
    endproperty
    a_rvld: assert property (p_rvld)
        else $error("read answer missing");
    property p_nvwr;
        STORE_ALL |=> NV_WR;
    endproperty
    a_nvwr: assert property (p_nvwr)
        else $error("store not written");
    property p_err;
        CMD_WR && CMD_CODE == `OLR_CMD_RESP && CMD_WDATA[5:3] != 3'h0
            && CMD_WDATA[5:3] != 3'h7 |=> STATUS[1:0] == 2'h3;
    endproperty
    a_err: assert property (p_err)
        else $error("bad retry accepted");
    property p_fstat;
        $rose(FAULT_FLAG) |-> STATUS[3] && STATUS[2];
    endproperty
    a_fstat: assert property (p_fstat)
        else $error("fault status missing");
    property p_wstat;
        $rose(WARN_FLAG) |-> STATUS[4] && STATUS[2];
    endproperty
    a_wstat: assert property (p_wstat)
        else $error("warn status missing");
    property p_alert;
        (|(STATUS & ~ALERT_MASK)) == !SMBALERT_N;
    endproperty
    a_alert: assert property (p_alert)
        else $error("alert mismatch");
    property p_sticky;
        !CLEAR_FAULTS |=> (STATUS & $past(STATUS)) == $past(STATUS);
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("status bit lost");
    property p_flags;
        $past(RSTN) && ($changed(FAULT_FLAG) || $changed(WARN_FLAG))
            |-> $past(TEMP_VLD, 2);
    endproperty
    a_flags: assert property (p_flags)
        else $error("flag moved without sample");
    property p_bg;
        $past(RSTN) && $rose(BANDGAP_OT) && !OUT_SHUTDOWN |=> OUT_SHUTDOWN;
    endproperty
    a_bg: assert property (p_bg)
        else $error("bandgap not shut down");
endmodule // olr_top_monitor

// File: bench/olr_host.sv
/* Command host model driving the decoded command strobes.
   Assumes a registered read answer one edge after the read. */
module olr_host (
    input wire clk,
    output logic wr,
    output logic rd,
    output logic [7:0] code,
    output logic [15:0] wdata,
    input wire [15:0] rdata,
    input wire rvld
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle bus at time zero
    initial begin
        wr = 1'b0;
        rd = 1'b0;
        code = 8'h00;
        wdata = 16'h0000;
    end
    // One write; released lines show the inverse
    task automatic cmd_write(input logic [7:0] c, input logic [15:0] d);
        @(posedge clk);
        #1;
        code = c;
        wdata = d;
        wr = 1'b1;
        @(posedge clk);
        #1;
        wr = 1'b0;
        code = ~c;
        wdata = ~d;
    endtask
    // One read; data taken as the answer appears
    task automatic cmd_read(input logic [7:0] c, output logic [15:0] d);
        @(posedge clk);
        #1;
        code = c;
        rd = 1'b1;
        @(posedge clk);
        #1;
        rd = 1'b0;
        code = ~c;
        d = (rvld === 1'b1) ? rdata : 16'hXXXX;
    endtask
endmodule // olr_host

// File: bench/olr_top_bench.sv
/* Self-checking bench for olr_top with host model and checker.
   Assumes CE held high; commanded off is a short level pulse. */
module olr_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic SYS_CLK, RSTN, CMD_WR, CMD_RD, CMD_RVLD, TEMP_VLD, BANDGAP_OT;
    logic LIMIT_CHECK_OVERRIDE, CLEAR_FAULTS, STORE_ALL, RESTORE_ALL;
    logic RISE_TICK, NV_WR, NV_SEL, NV_RS, SMBALERT_N, FAULT_FLAG;
    logic WARN_FLAG, OUT_SHUTDOWN, RESTART_REQ, OP_OFF;
    logic [7:0] CMD_CODE, NV_FLIM_IN, NV_FLIM;
    logic [15:0] CMD_WDATA, CMD_RDATA;
    logic [11:0] TEMP_DEG;
    logic [4:0] STATUS, ALERT_MASK;
    int bad_count = 0, n_checks = 0, n_rst = 0, cyc = 0;
    olr_top olr_top_i (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .CE(1'b1),
        .CMD_WR(CMD_WR), .CMD_RD(CMD_RD), .CMD_CODE(CMD_CODE),
        .CMD_WDATA(CMD_WDATA), .CMD_RDATA(CMD_RDATA), .CMD_RVLD(CMD_RVLD),
        .TEMP_VLD(TEMP_VLD), .TEMP_DEG(TEMP_DEG), .BANDGAP_OT(BANDGAP_OT),
        .LIMIT_CHECK_OVERRIDE(LIMIT_CHECK_OVERRIDE),
        .CLEAR_FAULTS(CLEAR_FAULTS), .ALERT_MASK(ALERT_MASK),
        .STORE_ALL(STORE_ALL), .RESTORE_ALL(RESTORE_ALL),
        .NV_FLIM_IN(NV_FLIM_IN), .NV_SEL_IN(1'b0), .NV_RS_IN(1'b1),
        .RISE_TICK(RISE_TICK), .OP_OFF(OP_OFF), .NV_WR(NV_WR),
        .NV_FLIM(NV_FLIM), .NV_SEL(NV_SEL), .NV_RS(NV_RS), .STATUS(STATUS),
        .SMBALERT_N(SMBALERT_N), .FAULT_FLAG(FAULT_FLAG),
        .WARN_FLAG(WARN_FLAG), .OUT_SHUTDOWN(OUT_SHUTDOWN),
        .RESTART_REQ(RESTART_REQ));
    olr_host olr_host_i (.clk(SYS_CLK), .wr(CMD_WR), .rd(CMD_RD),
        .code(CMD_CODE), .wdata(CMD_WDATA), .rdata(CMD_RDATA),
        .rvld(CMD_RVLD));
    // Clock and restart pulse counter
    initial begin
        SYS_CLK = 1'b0;
        forever #5 SYS_CLK = ~SYS_CLK;
    end
    always @(posedge SYS_CLK) begin
        if (RESTART_REQ === 1'b1) n_rst <= n_rst + 1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic stp(input int n);
        repeat (n) begin
            @(posedge SYS_CLK);
            #1;
        end
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        olr_host_i.cmd_write(c, d);
        stp(1);
    endtask
    task automatic rdc(input logic [7:0] c, input logic [15:0] e);
        logic [15:0] v;
        olr_host_i.cmd_read(c, v);
        chk(v, e);
    endtask
    task automatic smp(input logic [11:0] t);
        stp(1);
        TEMP_DEG = t;
        TEMP_VLD = 1'b1;
        stp(1);
        TEMP_VLD = 1'b0;
        stp(1);
    endtask
    task automatic clr();
        stp(1);
        CLEAR_FAULTS = 1'b1;
        stp(1);
        CLEAR_FAULTS = 1'b0;
        stp(1);
    endtask
    task automatic tk(input int n);
        repeat (n) begin
            stp(1);
            RISE_TICK = 1'b1;
            stp(1);
            RISE_TICK = 1'b0;
        end
    endtask
    task automatic t_limits();
        rdc(8'h4F, 16'h0091);
        rdc(8'h51, 16'h0078);
        wr(8'h4F, 16'h0077);
        chk(16'(STATUS), 16'h0003);
        rdc(8'h4F, 16'h0091);
        clr();
        wr(8'h4F, 16'h0078);
        chk(16'(STATUS), 16'h0003);
        chk(16'(SMBALERT_N), 16'h0000);
        clr();
        chk(16'(SMBALERT_N), 16'h0001);
        LIMIT_CHECK_OVERRIDE = 1'b1;
        wr(8'h4F, 16'h0078);
        rdc(8'h4F, 16'h0078);
        LIMIT_CHECK_OVERRIDE = 1'b0;
        ALERT_MASK = 5'h03;
        wr(8'h51, 16'h007D);
        chk(16'(STATUS), 16'h0003);
        chk(16'(SMBALERT_N), 16'h0001);
        rdc(8'h51, 16'h0078);
        clr();
        ALERT_MASK = 5'h00;
        wr(8'h4F, 16'hFFA5);
        rdc(8'h4F, 16'h00A5);
        wr(8'h4F, 16'h0091);
        clr();
        $display("t_limits done");
    endtask
    task automatic t_resp();
        rdc(8'h50, 16'h003F);
        for (int i = 0; i < 8; i++) begin
            wr(8'h50, {10'h000, i[2:0], 3'h0});
            chk(16'(STATUS), (i == 0 || i == 7) ? 16'h0 : 16'h3);
            rdc(8'h50, (i < 7) ? 16'h0000 : 16'h003F);
            clr();
        end
        $display("t_resp done");
    endtask
    task automatic t_temp();
        smp(12'd145);
        chk(16'(FAULT_FLAG), 16'h0000);
        chk(16'(STATUS), 16'h0014);
        smp(12'd146);
        chk(16'(FAULT_FLAG), 16'h0001);
        chk(16'(STATUS), 16'h001C);
        chk(16'(OUT_SHUTDOWN), 16'h0000);
        smp(12'd126);
        chk(16'(FAULT_FLAG), 16'h0001);
        smp(12'd125);
        chk(16'(FAULT_FLAG), 16'h0000);
        smp(12'd101);
        chk(16'(WARN_FLAG), 16'h0001);
        smp(12'd100);
        chk(16'(WARN_FLAG), 16'h0000);
        clr();
        $display("t_temp done");
    endtask
    task automatic t_retry();
        wr(8'h50, 16'h00B8);
        rdc(8'h50, 16'h00BF);
        smp(12'd146);
        chk(16'(OUT_SHUTDOWN), 16'h0001);
        smp(12'd125);
        tk(6);
        chk(16'(OUT_SHUTDOWN), 16'h0001);
        tk(1);
        stp(1);
        chk(16'(n_rst), 16'h0001);
        chk(16'(OUT_SHUTDOWN), 16'h0000);
        wr(8'h50, 16'h0080);
        smp(12'd146);
        smp(12'd125);
        tk(8);
        chk(16'(OUT_SHUTDOWN), 16'h0001);
        chk(16'(n_rst), 16'h0001);
        clr();
        chk(16'(OUT_SHUTDOWN), 16'h0000);
        wr(8'h50, 16'h0038);
        BANDGAP_OT = 1'b1;
        stp(2);
        chk(16'(OUT_SHUTDOWN), 16'h0001);
        BANDGAP_OT = 1'b0;
        stp(2);
        tk(7);
        stp(1);
        chk(16'(n_rst), 16'h0002);
        BANDGAP_OT = 1'b1;
        stp(2);
        chk(16'(OUT_SHUTDOWN), 16'h0001);
        BANDGAP_OT = 1'b0;
        OP_OFF = 1'b1;
        stp(2);
        OP_OFF = 1'b0;
        tk(7);
        stp(1);
        chk(16'(OUT_SHUTDOWN), 16'h0000);
        chk(16'(n_rst), 16'h0002);
        clr();
        $display("t_retry done");
    endtask
    task automatic t_nv();
        STORE_ALL = 1'b1;
        stp(1);
        STORE_ALL = 1'b0;
        chk(16'(NV_WR), 16'h0001);
        chk(16'(NV_FLIM), 16'h0091);
        chk({14'h0, NV_SEL, NV_RS}, 16'h0001);
        NV_FLIM_IN = 8'hA0;
        RESTORE_ALL = 1'b1;
        stp(1);
        RESTORE_ALL = 1'b0;
        rdc(8'h51, 16'h0087);
        NV_FLIM_IN = 8'h78;
        RESTORE_ALL = 1'b1;
        stp(1);
        RESTORE_ALL = 1'b0;
        rdc(8'h51, 16'h0064);
        $display("t_nv done");
    endtask
    // Main sequence
    initial begin
        RSTN = 1'b0;
        TEMP_VLD = 1'b0;
        TEMP_DEG = 12'h000;
        BANDGAP_OT = 1'b0;
        LIMIT_CHECK_OVERRIDE = 1'b0;
        CLEAR_FAULTS = 1'b0;
        STORE_ALL = 1'b0;
        RESTORE_ALL = 1'b0;
        NV_FLIM_IN = 8'h91;
        RISE_TICK = 1'b0;
        ALERT_MASK = 5'h00;
        OP_OFF = 1'b0;
        stp(20);
        RSTN = 1'b1;
        t_limits();
        t_resp();
        t_temp();
        t_retry();
        t_nv();
        report_and_stop();
    end
endmodule // olr_top_bench
bind olr_top olr_top_monitor olr_top_monitor_i (.SYS_CLK(SYS_CLK),
    .RSTN(RSTN), .CE(CE), .CMD_WR(CMD_WR), .CMD_RD(CMD_RD),
    .CMD_CODE(CMD_CODE), .CMD_WDATA(CMD_WDATA), .CMD_RDATA(CMD_RDATA),
    .CMD_RVLD(CMD_RVLD), .TEMP_VLD(TEMP_VLD), .BANDGAP_OT(BANDGAP_OT),
    .CLEAR_FAULTS(CLEAR_FAULTS), .ALERT_MASK(ALERT_MASK),
    .STORE_ALL(STORE_ALL), .RISE_TICK(RISE_TICK), .NV_WR(NV_WR),
    .STATUS(STATUS), .SMBALERT_N(SMBALERT_N), .FAULT_FLAG(FAULT_FLAG),
    .WARN_FLAG(WARN_FLAG), .OUT_SHUTDOWN(OUT_SHUTDOWN),
    .RESTART_REQ(RESTART_REQ));
